// ---- hw/typec_attach_pkg.sv ----
// Package: register map, field positions, reset values and configurations of the attach block.
package typec_attach_pkg;

    // ****************************************
    // Bus geometry and answers
    // ****************************************
    localparam int unsigned ADDR_W      = 4;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] PHY_OFS    = 4'h8;

    // ****************************************
    // Control register
    // ****************************************
    localparam int unsigned CTRL_EXT_MUX_BIT = 0;
    localparam logic        CTRL_EXT_MUX_RST = 1'b0;

    // ****************************************
    // Status register fields
    // ****************************************
    localparam int unsigned STAT_ATT_LSB   = 0;
    localparam int unsigned STAT_FLIP_LSB  = 3;
    localparam int unsigned STAT_CFG_LSB   = 5;
    localparam int unsigned STAT_POL_BIT   = 7;
    localparam int unsigned STAT_STRAP_BIT = 8;

    // ****************************************
    // PHY enable register fields
    // ****************************************
    localparam int unsigned PHY_CLK_LSB   = 0;
    localparam int unsigned PHY_LANEA_LSB = 4;
    localparam int unsigned PHY_LANEB_LSB = 8;

    // ****************************************
    // Receptacle configurations
    // ****************************************
    typedef enum logic [1:0] {
        CFG_EXT,
        CFG_MODE1,
        CFG_MODE2
    } cfg_t;

endpackage : typec_attach_pkg

// ---- hw/port_decode.sv ----
// Module: attach and orientation decode for one internally multiplexed port.
`timescale 1ns/10ps
module port_decode (
    input  wire logic mode2,
    input  wire logic pol_high,
    input  wire logic attach_raw,
    input  wire logic orient_raw,
    input  wire logic pair_a_raw,
    input  wire logic pair_b_raw,
    output logic      attached,
    output logic      flipped
);

    logic att_l;
    logic ori_l;
    logic a_l;
    logic b_l;

    // ****************************************
    // Decode
    // ****************************************
    always_comb
    begin
        // An input is active when its level equals the strapped polarity.
        att_l = attach_raw ~^ pol_high;
        ori_l = orient_raw ~^ pol_high;
        a_l   = pair_a_raw ~^ pol_high;
        b_l   = pair_b_raw ~^ pol_high;
        if (mode2)
        begin
            // Exactly one of the pair names the orientation; both or none is no attach.
            attached = a_l ^ b_l;
            flipped  = b_l & ~a_l;
        end
        else
        begin
            attached = att_l;
            flipped  = att_l & ori_l;
        end
    end

endmodule : port_decode

// ---- hw/typec_attach_phy_enable.sv ----
// Module: reversible-connector attach handling and 5 Gbps PHY enables with an AXI4-Lite slave.
// Function
// - Exactly three configurations exist: external lane mux, internal mux mode 1 and mode 2.
// - With the external mux, each port's attach input gates that port's PHY clock.
// - The active level of every attach and orientation input follows the polarity strap.
// - Internal mux mode 1 is chosen when the mode select input is low.
// - In mode 1 ports 1 and 2 combine attach and orientation inputs into attach and side.
// - In both internal modes only the lane matching attach and side is enabled.
// - Internal mux mode 2 is chosen when the mode select input is high.
// - In mode 2 the A and B pair of ports 1 and 2 gives attach and side.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module typec_attach_phy_enable (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [2:0]  attach_in,
    input  wire logic [2:1]  orientation_in,
    input  wire logic [2:1]  lane_pair_detect_a_in,
    input  wire logic [2:1]  lane_pair_detect_b_in,
    input  wire logic        internal_mux_mode_sel,
    input  wire logic        input_polarity_sel,
    output logic [2:0]       phy_clk_en,
    output logic [2:1]       phy_lane_a_en,
    output logic [2:1]       phy_lane_b_en
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
        logic                   aw_held;
        logic                   w_held;
        logic [3:0]             waddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   ext_mux;
        logic                   pol_high;
        logic                   strap_done;
        typec_attach_pkg::cfg_t cfg;
        logic [2:0]             att;
        logic [2:1]             flip;
        logic [2:0]             clk_en;
        logic [2:1]             lane_a;
        logic [2:1]             lane_b;
    } state_t;

    localparam state_t RST_STATE = '{
        awready    : 1'b1,
        wready     : 1'b1,
        arready    : 1'b1,
        ext_mux    : typec_attach_pkg::CTRL_EXT_MUX_RST,
        cfg        : typec_attach_pkg::CFG_MODE1,
        default    : '0
    };

    state_t                 st_ff;
    state_t                 nxt_st;
    typec_attach_pkg::cfg_t cfg_now;
    logic [2:0]             att;
    logic [2:1]             flip;
    logic [31:0]            ctrl_word;
    logic [31:0]            status_word;
    logic [31:0]            phy_word;

    // ****************************************
    // Configuration select
    // ****************************************
    // The mode select pin is expected to be pulled low on the board when left open.
    always_comb
    begin
        if (st_ff.ext_mux)
            cfg_now = typec_attach_pkg::CFG_EXT;
        else if (internal_mux_mode_sel)
            cfg_now = typec_attach_pkg::CFG_MODE2;
        else
            cfg_now = typec_attach_pkg::CFG_MODE1;
    end

    // ****************************************
    // Input decode
    // ****************************************
    // Port 0 has only an attach input; it is never internally multiplexed.
    assign att[0] = attach_in[0] ~^ st_ff.pol_high;

    generate
        for (genvar p = 1; p <= 2; p++)
        begin : g_port
            port_decode u_dec (
                .mode2      (cfg_now == typec_attach_pkg::CFG_MODE2),
                .pol_high   (st_ff.pol_high),
                .attach_raw (attach_in[p]),
                .orient_raw (orientation_in[p]),
                .pair_a_raw (lane_pair_detect_a_in[p]),
                .pair_b_raw (lane_pair_detect_b_in[p]),
                .attached   (att[p]),
                .flipped    (flip[p])
            );
        end
    endgenerate

    // ****************************************
    // Read words
    // ****************************************
    assign ctrl_word   = {31'h0, st_ff.ext_mux};
    assign status_word = {23'h0, st_ff.strap_done, st_ff.pol_high, st_ff.cfg,
                          st_ff.flip, st_ff.att};
    assign phy_word    = {22'h0, st_ff.lane_b, 2'h0, st_ff.lane_a, 1'h0, st_ff.clk_en};

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        nxt_st = st_ff;

        // The strap is caught on the first clock after reset release.
        if (!st_ff.strap_done)
        begin
            nxt_st.pol_high   = input_polarity_sel;
            nxt_st.strap_done = 1'b1;
        end

        nxt_st.cfg  = cfg_now;
        nxt_st.att  = att;
        nxt_st.flip = flip;
        case (cfg_now)
            typec_attach_pkg::CFG_EXT:
            begin
                // Lane choice is made by the outside mux, so only lane A is used.
                nxt_st.clk_en = att;
                nxt_st.lane_a = att[2:1];
                nxt_st.lane_b = 2'h0;
            end
            typec_attach_pkg::CFG_MODE1, typec_attach_pkg::CFG_MODE2:
            begin
                nxt_st.clk_en = att;
                nxt_st.lane_a = att[2:1] & ~flip;
                nxt_st.lane_b = att[2:1] & flip;
            end
            default:
            begin
                nxt_st.clk_en = 3'h0;
                nxt_st.lane_a = 2'h0;
                nxt_st.lane_b = 2'h0;
            end
        endcase
        // Until the polarity is known an idle input could look like an attach.
        if (!st_ff.strap_done)
        begin
            nxt_st.clk_en = 3'h0;
            nxt_st.lane_a = 2'h0;
            nxt_st.lane_b = 2'h0;
        end

        // Write channel: address and data are held until both are present.
        if (awvalid && st_ff.awready)
        begin
            nxt_st.aw_held = 1'b1;
            nxt_st.waddr   = awaddr;
        end
        if (wvalid && st_ff.wready)
        begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata  = wdata;
            nxt_st.wstrb  = wstrb;
        end
        if (st_ff.bvalid && bready)
            nxt_st.bvalid = 1'b0;
        if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid)
        begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = typec_attach_pkg::RESP_OKAY;
            case (st_ff.waddr)
                typec_attach_pkg::CTRL_OFS:
                begin
                    if (st_ff.wstrb[0])
                        nxt_st.ext_mux = st_ff.wdata[typec_attach_pkg::CTRL_EXT_MUX_BIT];
                end
                typec_attach_pkg::STATUS_OFS, typec_attach_pkg::PHY_OFS:
                begin
                    // Read-only registers ignore the write.
                end
                default:
                    nxt_st.bresp = typec_attach_pkg::RESP_SLVERR;
            endcase
        end
        nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_held && !nxt_st.bvalid;

        // Read channel: one read under way at a time.
        if (st_ff.rvalid && rready)
            nxt_st.rvalid = 1'b0;
        if (arvalid && st_ff.arready)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = typec_attach_pkg::RESP_OKAY;
            case (araddr)
                typec_attach_pkg::CTRL_OFS:   nxt_st.rdata = ctrl_word;
                typec_attach_pkg::STATUS_OFS: nxt_st.rdata = status_word;
                typec_attach_pkg::PHY_OFS:    nxt_st.rdata = phy_word;
                default:
                begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rresp = typec_attach_pkg::RESP_SLVERR;
                end
            endcase
        end
        nxt_st.arready = !nxt_st.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= RST_STATE;
        else
            st_ff <= nxt_st;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign awready       = st_ff.awready;
    assign wready        = st_ff.wready;
    assign bvalid        = st_ff.bvalid;
    assign bresp         = st_ff.bresp;
    assign arready       = st_ff.arready;
    assign rvalid        = st_ff.rvalid;
    assign rresp         = st_ff.rresp;
    assign rdata         = st_ff.rdata;
    assign phy_clk_en    = st_ff.clk_en;
    assign phy_lane_a_en = st_ff.lane_a;
    assign phy_lane_b_en = st_ff.lane_b;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence write_taken_s;
        st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    endsequence

    sequence resp_given_s;
        st_ff.bvalid && !st_ff.aw_held && !st_ff.w_held;
    endsequence

    cfg_legal_a: assert property (
        st_ff.cfg inside {typec_attach_pkg::CFG_EXT, typec_attach_pkg::CFG_MODE1,
                          typec_attach_pkg::CFG_MODE2})
        else $error("Configuration left the three legal values.");

    clk_gate_a: assert property (
        st_ff.strap_done && st_ff.ext_mux |=> phy_clk_en == $past(att) && phy_lane_b_en == 2'h0)
        else $error("External mux PHY clock does not follow attach.");

    pol_strap_a: assert property (
        $rose(st_ff.strap_done) |-> st_ff.pol_high == $past(input_polarity_sel))
        else $error("Polarity strap not caught after reset.");

    pol_hold_a: assert property (
        st_ff.strap_done |=> $stable(st_ff.pol_high))
        else $error("Polarity changed after it was caught.");

    mode1_sel_a: assert property (
        !st_ff.ext_mux && !internal_mux_mode_sel |=> st_ff.cfg == typec_attach_pkg::CFG_MODE1)
        else $error("Mode 1 not chosen with mode select low.");

    mode2_sel_a: assert property (
        !st_ff.ext_mux && internal_mux_mode_sel |=> st_ff.cfg == typec_attach_pkg::CFG_MODE2)
        else $error("Mode 2 not chosen with mode select high.");

    mode1_lane_a: assert property (
        st_ff.strap_done && cfg_now == typec_attach_pkg::CFG_MODE1 |=>
            phy_lane_a_en == $past(att[2:1] & ~flip) && phy_lane_b_en == $past(att[2:1] & flip))
        else $error("Mode 1 lane enable does not match attach and side.");

    one_lane_a: assert property (
        (phy_lane_a_en & phy_lane_b_en) == 2'h0 &&
        ((phy_lane_a_en | phy_lane_b_en) & ~phy_clk_en[2:1]) == 2'h0)
        else $error("Unused lane enabled.");

    mode2_pair_a: assert property (
        st_ff.strap_done && cfg_now == typec_attach_pkg::CFG_MODE2 &&
        (lane_pair_detect_a_in[1] ~^ st_ff.pol_high) &&
        (lane_pair_detect_b_in[1] ~^ st_ff.pol_high) |=> !phy_clk_en[1])
        else $error("Mode 2 pair with both sides active gave an attach.");

    reset_off_a: assert property (
        $rose(aresetn) |-> phy_clk_en == 3'h0 ##1 phy_clk_en == 3'h0 && phy_lane_a_en == 2'h0)
        else $error("PHY enabled before the polarity was known.");

    write_resp_a: assert property (
        write_taken_s |=> resp_given_s)
        else $error("Write response not given after address and data.");

endmodule : typec_attach_phy_enable

// ---- tb/attach_ctrl_model.sv ----
// Model of the outside attach controller that drives the hub's attach pins.
`timescale 1ns/10ps
module attach_ctrl_model (
    input  wire logic       act_high,
    input  wire logic [2:0] att,
    input  wire logic [2:1] flip,
    input  wire logic [2:1] both,
    output logic      [2:0] attach_in,
    output logic      [2:1] orientation_in,
    output logic      [2:1] pair_a,
    output logic      [2:1] pair_b
);
    // ****************************************
    // Pin encoding
    // ****************************************
    // Idle pins sit at the inactive level of the strap, so a wrong polarity reads as attach.
    assign attach_in      = att ^ {3{~act_high}};
    assign orientation_in = flip ^ {2{~act_high}};
    assign pair_a         = ((att[2:1] & ~flip) | both) ^ {2{~act_high}};
    assign pair_b         = ((att[2:1] & flip) | both) ^ {2{~act_high}};
endmodule : attach_ctrl_model

// ---- tb/typec_attach_phy_enable_tb.sv ----
// Testbench of the attach block: bus access, three configurations, polarity strap.
`timescale 1ns/10ps
module typec_attach_phy_enable_tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata;
    logic        internal_mux_mode_sel, input_polarity_sel;
    logic [2:0]  att;
    logic [2:1]  flip, both;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [2:0]  attach_in, phy_clk_en;
    wire  [2:1]  orientation_in, pair_a, pair_b, phy_lane_a_en, phy_lane_b_en;
    int          mismatches, tests_run, cycles;
    logic [31:0] d;
    logic [1:0]  r;

    typec_attach_phy_enable i_typec_attach_phy_enable (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .attach_in(attach_in), .orientation_in(orientation_in),
        .lane_pair_detect_a_in(pair_a), .lane_pair_detect_b_in(pair_b),
        .internal_mux_mode_sel(internal_mux_mode_sel),
        .input_polarity_sel(input_polarity_sel), .phy_clk_en(phy_clk_en),
        .phy_lane_a_en(phy_lane_a_en), .phy_lane_b_en(phy_lane_b_en));

    attach_ctrl_model i_attach_ctrl_model (
        .act_high(input_polarity_sel), .att(att), .flip(flip), .both(both),
        .attach_in(attach_in), .orientation_in(orientation_in), .pair_a(pair_a),
        .pair_b(pair_b));

    always #12.5 aclk = ~aclk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // A hang anywhere in the bus tasks ends here instead of running forever.
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Handshakes are judged on the falling edge, where they hold the value of the next rise.
    // Each task first steps to a rising edge, so a request never starts on a falling edge
    // and a ready seen low there is never mistaken for one that has already been used.
    task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa | pw)
        begin
            @(negedge aclk);
            if (awready) pa = 1'b0;
            if (wready) pw = 1'b0;
            @(posedge aclk);
            if (!pa) awvalid <= 1'b0;
            if (!pw) wvalid <= 1'b0;
        end
        do @(negedge aclk); while (!bvalid);
        rs = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        v = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : axi_read

    function automatic logic [6:0] expect_en(input typec_attach_pkg::cfg_t c, input logic [6:0] v);
        logic [2:0] a;
        logic [2:1] f, x;
        a = v[2:0];
        f = v[4:3];
        x = (c == typec_attach_pkg::CFG_MODE2) ? a[2:1] & ~v[6:5] : a[2:1];
        if (c == typec_attach_pkg::CFG_EXT)
            return {2'h0, a[2:1], a};
        return {x & f, x & ~f, x, a[0]};
    endfunction : expect_en

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic reset_dut(input logic pol);
        @(posedge aclk);
        aresetn <= 1'b0;
        input_polarity_sel <= pol;
        {both, flip, att} <= 7'h07;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2)
        begin
            @(negedge aclk);
            check({25'h0, phy_lane_b_en, phy_lane_a_en, phy_clk_en}, 32'h0);
        end
        axi_read(typec_attach_pkg::CTRL_OFS, d, r);
        check(d, 32'h0);
        $display("reset with strap %0d done", pol);
    endtask : reset_dut

    task automatic sweep(input typec_attach_pkg::cfg_t c);
        logic [6:0]  e;
        logic [31:0] x;
        axi_read(typec_attach_pkg::STATUS_OFS, d, r);
        check({30'h0, d[6:5]}, {30'h0, c});
        check({31'h0, d[7]}, {31'h0, input_polarity_sel});
        for (int v = 0; v < 128; v++)
        begin
            @(posedge aclk);
            {both, flip, att} <= v[6:0];
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            check({25'h0, phy_lane_b_en, phy_lane_a_en, phy_clk_en},
                  {25'h0, expect_en(c, v[6:0])});
        end
        // The registers must report the lanes and attaches that the last vector left behind.
        e = expect_en(c, 7'h7F);
        x = (32'(e[2:0]) << typec_attach_pkg::PHY_CLK_LSB) |
            (32'(e[4:3]) << typec_attach_pkg::PHY_LANEA_LSB) |
            (32'(e[6:5]) << typec_attach_pkg::PHY_LANEB_LSB);
        axi_read(typec_attach_pkg::PHY_OFS, d, r);
        check(d, x);
        axi_read(typec_attach_pkg::STATUS_OFS, d, r);
        check({23'h0, d[8], 5'h0, d[2:0]}, {23'h0, 1'b1, 5'h0, e[2:0]});
        $display("sweep of configuration %0d done", c);
    endtask : sweep

    task automatic bus_map();
        axi_write(typec_attach_pkg::STATUS_OFS, 32'hFFFF_FFFF, r);
        check({30'h0, r}, {30'h0, typec_attach_pkg::RESP_OKAY});
        axi_write(4'hC, 32'h0, r);
        check({30'h0, r}, {30'h0, typec_attach_pkg::RESP_SLVERR});
        axi_read(4'hC, d, r);
        check({30'h0, r}, {30'h0, typec_attach_pkg::RESP_SLVERR});
        check(d, 32'h0);
        axi_read(typec_attach_pkg::CTRL_OFS, d, r);
        check(d, 32'h1);
        $display("register map test done");
    endtask : bus_map

    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wstrb, wdata} = 44'h0;
        {internal_mux_mode_sel, input_polarity_sel, att, flip, both} = 9'h0;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        reset_dut(1'b1);
        sweep(typec_attach_pkg::CFG_MODE1);
        @(posedge aclk);
        internal_mux_mode_sel <= 1'b1;
        sweep(typec_attach_pkg::CFG_MODE2);
        axi_write(typec_attach_pkg::CTRL_OFS, 32'h1, r);
        check({30'h0, r}, {30'h0, typec_attach_pkg::RESP_OKAY});
        sweep(typec_attach_pkg::CFG_EXT);
        bus_map();
        reset_dut(1'b0);
        sweep(typec_attach_pkg::CFG_MODE2);
        @(posedge aclk);
        internal_mux_mode_sel <= 1'b0;
        sweep(typec_attach_pkg::CFG_MODE1);
        results();
    end
endmodule : typec_attach_phy_enable_tb
